// File: angle_out_consts.svh
// Named constants for the angle output block: register map, reset values, timing.
// Assumes inclusion by bare name from each design file.
`ifndef ANGLE_OUT_CONSTS_SVH
`define ANGLE_OUT_CONSTS_SVH

`define REG_INDEX_SHAPE   6'h04
`define REG_PPR_LO        6'h07
`define REG_PPR_HI        6'h08
`define REG_LOCK          6'h09
`define PPR_RESET         10'h3FF
`define CAP_RESET         3'h0
`define INDEX_RESET       8'h00
`define LOCK_BIT          0
`define IDX_OFFSET_LSB    0
`define IDX_WIDTH_LSB     2
`define CAP_LSB           2
`define CLK_HZ            40000000
`define CLK_NS            25
`define INCR_FMAX_HZ      16000000
`define MONO_NS           33000
`define SSI_CYCLES        5'd17
`define SSI_WORD          16
`define CRC_POLY_REFL     4'hC
`define POS_BITS          12
`define PWM_HZ            972
`define PWM_LEAD          15'd32
`define PWM_FRAME         (16384 + 64)

`endif

// File: angle_out_pkg.sv
// Types for the angle output block: the packed state of each module.
// Assumes the constants header is compiled alongside.
package angle_out_pkg;

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        prev;
        logic        busy;
        logic [4:0]  cnt;
        logic [15:0] shreg;
        logic [10:0] mono;
        logic        dout;
    } ssi_state_t;

    typedef struct packed {
        logic [25:0] acc;
        logic [14:0] unit;
        logic [13:0] duty;
        logic        out;
    } pwm_state_t;

    typedef struct packed {
        logic [7:0]  index_shape;
        logic [9:0]  ppr;
        logic [2:0]  cap;
        logic        lock;
        logic [7:0]  rdata;
        logic [15:0] frame;
        logic        fvalid;
        logic [15:0] filt;
        logic        started;
        logic [11:0] cur;
        logic [7:0]  ratecnt;
        logic        qa;
        logic        qb;
        logic        qz;
    } main_state_t;

endpackage

// File: ssi_slave.sv
// SSI slave that shifts out a frozen angle word on the master's clock.
// Assumes angle_in is on clk; ssi_clock_in is an asynchronous pin.
`include "angle_out_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module ssi_slave #(
    parameter int ANGLE_W = 16
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] angle_in,
    input  wire logic        ssi_clock_in,
    output logic             ssi_data_out
);

    localparam logic [10:0] MONO_CYC = 11'((`MONO_NS + `CLK_NS - 1) / `CLK_NS);

    angle_out_pkg::ssi_state_t s_ff, nxt_s;
    logic rise;
    logic fall;

    assign ssi_data_out = s_ff.dout;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.sync1 = ssi_clock_in;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.prev = s_ff.sync2;
        rise = s_ff.sync2 & ~s_ff.prev;
        fall = ~s_ff.sync2 & s_ff.prev;
        if (rise && !s_ff.busy) begin
            nxt_s.busy = 1'b1;
            nxt_s.cnt = 5'd1;
            nxt_s.shreg = angle_in << (`SSI_WORD - ANGLE_W);
            nxt_s.mono = MONO_CYC;
        end else if (rise) begin
            nxt_s.mono = MONO_CYC;
            if (s_ff.cnt < `SSI_CYCLES) begin
                nxt_s.dout = s_ff.shreg[15];
                nxt_s.shreg = {s_ff.shreg[14:0], 1'b0};
                nxt_s.cnt = s_ff.cnt + 5'd1;
            end else begin
                nxt_s.dout = 1'b0;
            end
        end else if (fall && s_ff.busy) begin
            nxt_s.mono = MONO_CYC;
        end else if (s_ff.busy && s_ff.sync2) begin
            if (s_ff.mono == 11'd0) begin
                nxt_s.busy = 1'b0;
                nxt_s.dout = 1'b1;
            end else begin
                nxt_s.mono = s_ff.mono - 11'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_ff <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, busy: 1'b0, cnt: 5'd0,
                      shreg: 16'h0000, mono: 11'd0, dout: 1'b1};
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule // ssi_slave

`default_nettype wire

// File: pwm_gen.sv
// PWM output carrying the 14-bit absolute angle, one frame per period.
// Assumes angle_in is on clk.
`include "angle_out_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module pwm_gen (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] angle_in,
    output logic             pwm_out
);

    // A fractional accumulator keeps the frame rate exact although one time unit
    // is not a whole number of clock cycles.
    localparam logic [25:0] STEP  = 26'(`PWM_HZ * `PWM_FRAME);
    localparam logic [25:0] LIMIT = 26'(`CLK_HZ);
    localparam logic [14:0] LAST  = 15'(`PWM_FRAME - 1);

    angle_out_pkg::pwm_state_t s_ff, nxt_s;

    assign pwm_out = s_ff.out;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.acc = s_ff.acc + STEP;
        if (nxt_s.acc >= LIMIT) begin
            nxt_s.acc = nxt_s.acc - LIMIT;
            if (s_ff.unit == LAST) begin
                nxt_s.unit = 15'd0;
                nxt_s.duty = angle_in[15:2];
            end else begin
                nxt_s.unit = s_ff.unit + 15'd1;
            end
        end
        nxt_s.out = nxt_s.unit < (`PWM_LEAD + {1'b0, nxt_s.duty});
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_ff <= '{acc: 26'd0, unit: 15'd0, duty: 14'd0, out: 1'b1};
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule // pwm_gen

`default_nettype wire

// File: angle_output_interfaces.sv
// Angle output side: config registers with write lock, CRC angle frame,
// SSI slave, quadrature with index and rate cap, PWM output.
// Assumes a decoded register request port from the serial framer and an
// angle word on clk from the angle engine.
//
// Overview of operation
// - While write lock is set, configuration writes are ignored; only angle reads and the lock register work.
// - Clearing write lock makes configuration registers writable again.
// - CRC angle answer is 12-bit position MSB first, then 4-bit CRC.
// - CRC uses x^4+x+1, zero init, zero final XOR, reflected in and out.
// - An SSI read starts on a rising SSI clock; at most 17 cycles.
// - First SSI cycle is a dummy; MSB comes in the second cycle.
// - Angles shorter than 16 bits are zero padded; master may stop early.
// - The latched angle stays frozen until last rising edge plus monoflop time.
// - The SSI port only delivers angle data, no register access.
// - Full resolution gives 4096 steps, 1024 A/B periods per turn.
// - Counterclockwise B leads A by quarter period; clockwise A leads B.
// - All quadrature and index outputs are high during power-up.
// - Resolution code N gives N+1 periods and 4(N+1) steps per turn.
// - Rate cap code k limits output frequency to 16 MHz over 2^k.
// - Index gives one rising edge per turn at the zero position.
// - Index width and position are two 2-bit fields at 0x4, reset 00.
// - Quadrature output moves only after angle change exceeds a threshold.
// - PWM carries a 14-bit angle at a 972 Hz frame rate.
// - PWM frame is 16384+64 units; high time is 32 plus angle code.
`include "angle_out_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module angle_output_interfaces #(
    parameter int          ANGLE_W     = 16,
    parameter bit          CRC_OUT     = 1'b1,
    parameter logic [15:0] HYST_LSB    = 16'h0008,
    parameter logic [11:0] IDX_W_UNIT  = 12'd1,
    parameter logic [11:0] IDX_D_UNIT  = 12'd1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] angle_in,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [5:0]  cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    output logic [7:0]       cfg_rdata,
    input  wire logic        angle_rd,
    output logic [15:0]      angle_frame,
    output logic             angle_frame_valid,
    input  wire logic        ssi_clock_in,
    output logic             ssi_data_out,
    output logic             quad_a,
    output logic             quad_b,
    output logic             quad_index,
    output logic             pwm_out
);

    ////////////////////////////////////////////////////////////////////////////

    // Reflected CRC: each byte goes in LSB first, high byte first.
    function automatic logic [3:0] crc4(input logic [15:0] word);
        logic [3:0] c;
        logic       fb;
        c = 4'h0;
        for (int b = 1; b >= 0; b--) begin
            for (int i = 0; i < 8; i++) begin
                fb = c[0] ^ word[b * 8 + i];
                c = {1'b0, c[3:1]};
                if (fb) begin
                    c = c ^ `CRC_POLY_REFL;
                end
            end
        end
        return c;
    endfunction

    // Least step spacing in cycles; four steps make one output period.
    function automatic logic [7:0] step_gap(input logic [2:0] k);
        longint num;
        longint den;
        num = longint'(`CLK_HZ) << k;
        den = 4 * longint'(`INCR_FMAX_HZ);
        return 8'((num + den - 1) / den);
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    angle_out_pkg::main_state_t s_ff, nxt_s;

    logic        wr_ok;
    logic        rd_ok;
    logic [15:0] diff;
    logic [15:0] mag;
    logic [12:0] steps;
    logic [28:0] prod;
    logic [11:0] target;
    logic [12:0] fwd;
    logic [11:0] nxt_pos;
    logic [11:0] zwin;
    logic [11:0] zw;
    logic [11:0] zd;
    logic [11:0] pos12;

    assign cfg_rdata         = s_ff.rdata;
    assign angle_frame       = s_ff.frame;
    assign angle_frame_valid = s_ff.fvalid;
    assign quad_a            = s_ff.qa;
    assign quad_b            = s_ff.qb;
    assign quad_index        = s_ff.qz;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.fvalid = 1'b0;

        // Register port. The lock register itself stays writable, else the
        // lock could never be lifted.
        wr_ok = cfg_wr && (!s_ff.lock || cfg_addr == `REG_LOCK);
        rd_ok = cfg_rd && (!s_ff.lock || cfg_addr == `REG_LOCK);
        if (wr_ok) begin
            case (cfg_addr)
                `REG_INDEX_SHAPE: nxt_s.index_shape = cfg_wdata;
                `REG_PPR_LO: nxt_s.ppr[7:0] = cfg_wdata;
                `REG_PPR_HI: begin
                    nxt_s.ppr[9:8] = cfg_wdata[1:0];
                    nxt_s.cap = cfg_wdata[`CAP_LSB +: 3];
                end
                `REG_LOCK: nxt_s.lock = cfg_wdata[`LOCK_BIT];
                default: begin
                end
            endcase
        end
        if (rd_ok) begin
            case (cfg_addr)
                `REG_INDEX_SHAPE: nxt_s.rdata = s_ff.index_shape;
                `REG_PPR_LO: nxt_s.rdata = s_ff.ppr[7:0];
                `REG_PPR_HI: nxt_s.rdata = {3'b000, s_ff.cap, s_ff.ppr[9:8]};
                `REG_LOCK: nxt_s.rdata = {7'b0000000, s_ff.lock};
                default: nxt_s.rdata = 8'h00;
            endcase
        end

        // Angle read answer.
        pos12 = angle_in[15 -: `POS_BITS];
        if (angle_rd) begin
            nxt_s.fvalid = 1'b1;
            if (CRC_OUT) begin
                nxt_s.frame = {pos12, crc4({4'h0, pos12})};
            end else begin
                nxt_s.frame = angle_in;
            end
        end

        // Hysteresis on the angle seen by the quadrature path.
        diff = angle_in - s_ff.filt;
        mag = diff[15] ? (16'h0000 - diff) : diff;
        if (mag > HYST_LSB) begin
            nxt_s.filt = angle_in;
        end

        // Target step position within one turn.
        steps = {11'(s_ff.ppr) + 11'd1, 2'b00};
        prod = {13'd0, s_ff.filt} * {16'd0, steps};
        target = prod[27:16];

        fwd = (target >= s_ff.cur) ? {1'b0, target - s_ff.cur}
                                   : {1'b0, target} + steps - {1'b0, s_ff.cur};
        nxt_pos = s_ff.cur;
        if (!s_ff.started) begin
            nxt_s.started = 1'b1;
            nxt_pos = target;
            nxt_s.ratecnt = step_gap(s_ff.cap);
        end else if (s_ff.ratecnt != 8'd0) begin
            nxt_s.ratecnt = s_ff.ratecnt - 8'd1;
        end else if (target != s_ff.cur) begin
            nxt_s.ratecnt = step_gap(s_ff.cap) - 8'd1;
            // A shrunk resolution can leave the position beyond the new turn;
            // walking it down keeps A and B changing one at a time.
            if ({1'b0, s_ff.cur} < steps && fwd <= {1'b0, steps[12:1]}) begin
                nxt_pos = ({1'b0, s_ff.cur} + 13'd1 == steps) ? 12'd0 : s_ff.cur + 12'd1;
            end else begin
                nxt_pos = (s_ff.cur == 12'd0) ? 12'(steps - 13'd1) : s_ff.cur - 12'd1;
            end
        end
        nxt_s.cur = nxt_pos;

        // Rising angle walks 00,10,11,01 on A,B so A leads; falling reverses.
        nxt_s.qa = nxt_pos[1] ^ nxt_pos[0];
        nxt_s.qb = nxt_pos[1];

        zw = (12'(s_ff.index_shape[`IDX_WIDTH_LSB +: 2]) + 12'd1) * IDX_W_UNIT;
        zd = 12'(s_ff.index_shape[`IDX_OFFSET_LSB +: 2]) * IDX_D_UNIT;
        zwin = (nxt_pos >= zd) ? nxt_pos - zd : 12'(nxt_pos + steps - {1'b0, zd});
        nxt_s.qz = zwin < zw;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_ff <= '{index_shape: `INDEX_RESET, ppr: `PPR_RESET, cap: `CAP_RESET,
                      lock: 1'b0, rdata: 8'h00, frame: 16'h0000, fvalid: 1'b0,
                      filt: 16'h0000, started: 1'b0, cur: 12'd0, ratecnt: 8'd0,
                      qa: 1'b1, qb: 1'b1, qz: 1'b1};
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // The SSI path sees only the angle; it has no route to the registers.
    ssi_slave #(
        .ANGLE_W (ANGLE_W)
    ) u_ssi (
        .clk          (clk),
        .rst_n        (rst_n),
        .angle_in     (angle_in),
        .ssi_clock_in (ssi_clock_in),
        .ssi_data_out (ssi_data_out)
    );

    pwm_gen u_pwm (
        .clk      (clk),
        .rst_n    (rst_n),
        .angle_in (angle_in),
        .pwm_out  (pwm_out)
    );

endmodule // angle_output_interfaces

`default_nettype wire

// File: angle_output_props.sv
// Checker for the angle output block: register lock, angle frame, SSI, quadrature, PWM.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module angle_output_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] angle_in,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [5:0]  cfg_addr,
    input wire logic [7:0]  cfg_wdata,
    input wire logic [7:0]  cfg_rdata,
    input wire logic        angle_rd,
    input wire logic [15:0] angle_frame,
    input wire logic        angle_frame_valid,
    input wire logic        ssi_clock_in,
    input wire logic        ssi_data_out,
    input wire logic        quad_a,
    input wire logic        quad_b,
    input wire logic        quad_index,
    input wire logic        pwm_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the lock bit, time since reset, and time the SSI clock has stood high.
    logic        lock_ff;
    logic [2:0]  up_ff;
    logic [10:0] hi_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_ff <= 1'b0;
            up_ff   <= 3'h0;
            hi_ff   <= 11'h000;
        end else begin
            if (cfg_wr && cfg_addr == 6'h09) lock_ff <= cfg_wdata[0];
            if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
            hi_ff <= !ssi_clock_in ? 11'h000 : (hi_ff == 11'd1400) ? hi_ff : hi_ff + 11'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence idle_then_fall;
        (hi_ff == 11'd1400) ##1 !ssi_clock_in;
    endsequence
    chk_quad_reset_high: assert property ($rose(rst_n) |-> quad_a && quad_b && quad_index)
        else $error("quadrature not high after reset");
    chk_frame_valid_pulse: assert property (angle_rd |=> angle_frame_valid)
        else $error("no frame valid after angle read");
    chk_frame_valid_cause: assert property (angle_frame_valid |-> $past(angle_rd))
        else $error("frame valid without angle read");
    chk_frame_pos_bits: assert property (angle_frame_valid |->
        {4'h0, angle_frame[15:4]} == ($past(angle_in) >> 4))
        else $error("frame position bits wrong");
    chk_locked_read_hold: assert property (cfg_rd && lock_ff && cfg_addr != 6'h09
        |=> $stable(cfg_rdata))
        else $error("locked read changed read data");
    chk_lock_read_back: assert property (cfg_rd && !cfg_wr && cfg_addr == 6'h09
        |=> cfg_rdata == {7'h00, lock_ff})
        else $error("lock bit read back wrong");
    chk_ssi_idle_high: assert property (hi_ff == 11'd1400 |-> ssi_data_out)
        else $error("SSI data not high when idle");
    chk_ssi_dummy_cycle: assert property (idle_then_fall |-> ssi_data_out [*8])
        else $error("SSI data moved in dummy cycle");
    chk_quad_one_change: assert property (up_ff == 3'h7 |->
        !($changed(quad_a) && $changed(quad_b)))
        else $error("A and B changed together");
    chk_pwm_lead_high: assert property ($rose(pwm_out) |=> pwm_out [*8])
        else $error("PWM high time too short");
endmodule // angle_output_props

bind angle_output_interfaces angle_output_props u_props (
    .clk, .rst_n, .angle_in, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .angle_rd, .angle_frame, .angle_frame_valid, .ssi_clock_in, .ssi_data_out,
    .quad_a, .quad_b, .quad_index, .pwm_out
);
`default_nettype wire

// File: ssi_master_model.sv
// SSI master model that clocks angle words out of the slave.
// Assumes only the bench calls xfer; the clock stands high between frames.
`timescale 1ns/100ps
`default_nettype none

module ssi_master_model (
    output var logic  ssi_clock_in,
    input  wire logic ssi_data_out
);
    initial ssi_clock_in = 1'b1;
    // Samples late in each period, since the slave moves its data some cycles after a rise.
    task automatic xfer(input int n, output logic [15:0] word);
        word = 16'h0000;
        ssi_clock_in = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            ssi_clock_in = 1'b1;
            // Halves are far shorter than a real master allows, to keep the run short;
            // the slave only needs each half to span a few clock cycles.
            #100;
            if (i < n - 1) ssi_clock_in = 1'b0;
            #90;
            if (i > 0) word = {word[14:0], ssi_data_out};
            #10;
        end
        #53000;
    endtask
endmodule // ssi_master_model
`default_nettype wire

// File: test_angle_output_interfaces.sv
// Bench for the angle output block: register port, angle frame, SSI, quadrature, PWM.
// Assumes the checker is bound in and the SSI master model sits on the far side.
`timescale 1ns/100ps
`default_nettype none

module test_angle_output_interfaces;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] angle_in = 16'h0000;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [5:0]  cfg_addr = 6'h00;
    logic [7:0]  cfg_wdata = 8'h00;
    logic        angle_rd = 1'b0;
    logic [7:0]  cfg_rdata;
    logic [15:0] angle_frame;
    logic        angle_frame_valid, ssi_clock_in, ssi_data_out;
    logic        quad_a, quad_b, quad_index, pwm_out;
    logic [15:0] w;
    logic        pa, pb, pz, dir_up, pwm_done = 1'b0;
    int          miscompares = 0, checks_done = 0, cyc = 0;
    int          edges, a_rises, z_rises, bad_dir, h, f;
    int          sp[8] = '{1, 2, 3, 5, 10, 20, 40, 80};
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
    always #12.5 clk = ~clk;
    angle_output_interfaces u_dut (.clk, .rst_n, .angle_in, .cfg_wr, .cfg_rd, .cfg_addr,
        .cfg_wdata, .cfg_rdata, .angle_rd, .angle_frame, .angle_frame_valid,
        .ssi_clock_in, .ssi_data_out, .quad_a, .quad_b, .quad_index, .pwm_out);
    ssi_master_model u_ssi (.ssi_clock_in, .ssi_data_out);
    ////////////////////////////////////////////////////////////////////////////////
    // Outputs are looked at 2 ns after the edge, so they have settled.
    always @(posedge clk) begin
        #2;
        cyc++;
        if (quad_a !== pa || quad_b !== pb) edges++;
        if (quad_a && !pa) a_rises++;
        if (quad_a && !pa && quad_b !== !dir_up) bad_dir++;
        if (quad_index && !pz) z_rises++;
        pa = quad_a;
        pb = quad_b;
        pz = quad_index;
        if (cyc == 70000) begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        `CHK("cfg_rdata", e, cfg_rdata)
    endtask
    task automatic arq(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk);
        angle_in = a;
        angle_rd = 1'b1;
        @(negedge clk);
        angle_rd = 1'b0;
        `CHK("frame_valid", 1'b1, angle_frame_valid)
        `CHK("angle_frame", e, angle_frame)
    endtask
    // One full turn in equal angle steps, counting A and index rises on the way.
    task automatic sweep(input int stp, input logic up);
        angle_in = 16'h0000;
        repeat (300) @(negedge clk);
        dir_up = up;
        a_rises = 0;
        z_rises = 0;
        bad_dir = 0;
        for (int i = 1; i <= 65536 / stp; i++) begin
            angle_in = up ? 16'(i * stp) : 16'(-i * stp);
            repeat (4) @(negedge clk);
        end
        repeat (20) @(negedge clk);
        `CHK("index_rises", 1, z_rises)
        `CHK("direction", 0, bad_dir)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // The first frame starts at reset with a lead-only high time; the second carries 0x4000.
    initial begin
        @(posedge rst_n);
        h = 0;
        while (pwm_out === 1'b1) begin
            @(negedge clk);
            h++;
        end
        `CHK("pwm_lead", 1'b1, h >= 78 && h <= 82)
        f = h;
        while (pwm_out !== 1'b1) begin
            @(negedge clk);
            f++;
        end
        `CHK("pwm_frame", 1'b1, f >= 41148 && f <= 41156)
        h = 0;
        while (pwm_out === 1'b1) begin
            @(negedge clk);
            h++;
        end
        `CHK("pwm_high", 1'b1, h >= 10324 && h <= 10332)
        pwm_done = 1'b1;
    end
    initial begin
        repeat (16) @(negedge clk);
        `CHK("quad_reset", 3'b111, {quad_a, quad_b, quad_index})
        rst_n = 1'b1;
        rd(6'h04, 8'h00);
        rd(6'h07, 8'hFF);
        rd(6'h08, 8'h03);
        rd(6'h3F, 8'h00);
        wr(6'h09, 8'h01);
        wr(6'h04, 8'h0F);
        rd(6'h09, 8'h01);
        rd(6'h04, 8'h01);
        arq(16'h3EB0, 16'h3EB7);
        wr(6'h09, 8'h00);
        rd(6'h04, 8'h00);
        wr(6'h04, 8'h0F);
        rd(6'h04, 8'h0F);
        arq(16'h0FF0, 16'h0FF2);
        angle_in = 16'hA5C3;
        fork
            u_ssi.xfer(17, w);
            begin
                repeat (40) @(negedge clk);
                angle_in = 16'h1234;
            end
        join
        `CHK("ssi_word", 16'hA5C3, w)
        u_ssi.xfer(17, w);
        `CHK("ssi_word", 16'h1234, w)
        u_ssi.xfer(5, w);
        `CHK("ssi_short", 16'h0001, w)
        wr(6'h07, 8'h03);
        wr(6'h08, 8'h00);
        sweep(256, 1'b1);
        `CHK("a_rises", 4, a_rises)
        sweep(256, 1'b0);
        `CHK("a_rises", 4, a_rises)
        wr(6'h07, 8'hFF);
        wr(6'h08, 8'h03);
        sweep(16, 1'b1);
        `CHK("a_rises", 1024, a_rises)
        for (int k = 0; k < 8; k++) begin
            wr(6'h08, {3'h0, 3'(k), 2'h3});
            angle_in = 16'h0000;
            repeat (16 * sp[k] + 50) @(negedge clk);
            edges = 0;
            angle_in = 16'h0100;
            while (edges == 0) @(negedge clk);
            repeat (8 * sp[k]) @(negedge clk);
            `CHK("rate_cap", 1'b1, edges >= 8 && edges <= 9)
            repeat (8 * sp[k] + 20) @(negedge clk);
            `CHK("rate_steps", 16, edges)
        end
        wr(6'h08, 8'h03);
        angle_in = 16'h1000;
        repeat (300) @(negedge clk);
        edges = 0;
        for (int i = 0; i < 20; i++) begin
            angle_in = i[0] ? 16'h0FF9 : 16'h1007;
            repeat (3) @(negedge clk);
        end
        `CHK("hysteresis", 0, edges)
        angle_in = 16'h4000;
        wait (pwm_done);
        results();
    end
`undef CHK
endmodule // test_angle_output_interfaces
`default_nettype wire
